// ===== clkout_divider_status.sv
// Clock-output source select and divider chain, trim register and status register.
`timescale 1ns/1ps
`default_nettype none
module clkout_divider_status (
  input  wire logic       i_clk_sys,                  // Reference clock, 125 MHz.
  input  wire logic       i_srst,                     // Synchronous reset, active high.
  input  wire logic [7:0] i_reg_addr,                 // Register offset.
  input  wire logic       i_reg_wr,                   // Write strobe, one cycle.
  input  wire logic [7:0] i_reg_wdata,                // Write data.
  input  wire logic       i_reg_rd,                   // Read strobe, one cycle.
  output logic      [7:0] o_reg_rdata,                // Read data, held until next read.
  output logic            o_reg_rvalid,               // Read data valid pulse.
  input  wire logic [7:0] i_compare_divider_setting,  // Compare divider setting.
  input  wire logic       i_power_amp_enabled,        // Amplifier enabled level.
  input  wire logic       i_tx_active_entry,          // Pulse on transmit-mode entry.
  input  wire logic       i_crystal_amplitude_ok,     // Crystal amplitude check level.
  input  wire logic       i_undervoltage_detect,      // Under-voltage event.
  input  wire logic       i_vco_calibration_error,    // VCO calibration error event.
  input  wire logic       i_pll_unlock,               // PLL loss-of-lock event.
  output logic      [1:0] o_undervoltage_threshold_select, // Threshold code.
  output logic      [4:0] o_antenna_cap_trim,         // Antenna capacitance code.
  output logic            o_clock_output_pin,         // Clock output pin level.
  output logic            o_clock_output_pin_oe_n     // Pin enable, low while driving.
);

  import clkout_pkg::*;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] clock_output_source_divider;
  logic [7:0] undervoltage_antenna_trim;

  logic [2:0] clock_output_source_select;
  logic [2:0] prescale_ratio_select;
  logic [1:0] post_divider_ratio_select;

  logic       sel_src;
  logic       sel_trim;
  logic       sel_stat;
  logic       wr_src;
  logic       wr_trim;
  logic       rd_stat;

  assign sel_src  = (i_reg_addr == OFS_CLOCK_OUTPUT_SOURCE_DIVIDER);
  assign sel_trim = (i_reg_addr == OFS_UNDERVOLTAGE_ANTENNA_TRIM);
  assign sel_stat = (i_reg_addr == OFS_ERROR_DETECTION_STATUS);
  assign wr_src   = i_reg_wr && sel_src;
  assign wr_trim  = i_reg_wr && sel_trim;
  assign rd_stat  = i_reg_rd && sel_stat;

  assign clock_output_source_select = clock_output_source_divider[SRC_SEL_MSB:SRC_SEL_LSB];
  assign prescale_ratio_select      = clock_output_source_divider[PRESCALE_MSB:PRESCALE_LSB];
  assign post_divider_ratio_select  = clock_output_source_divider[POSTDIV_MSB:POSTDIV_LSB];

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      clock_output_source_divider <= RST_CLOCK_OUTPUT_SOURCE_DIVIDER;
    end else if (wr_src) begin
      clock_output_source_divider <= i_reg_wdata;
    end
  end

  // Bit 7 of the trim register is unused and always reads zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      undervoltage_antenna_trim <= RST_UNDERVOLTAGE_ANTENNA_TRIM;
    end else if (wr_trim) begin
      undervoltage_antenna_trim <= {1'b0, i_reg_wdata[6:0]};
    end
  end

  assign o_undervoltage_threshold_select = undervoltage_antenna_trim[UV_THRESH_MSB:UV_THRESH_LSB];
  assign o_antenna_cap_trim              = undervoltage_antenna_trim[ANT_TRIM_MSB:ANT_TRIM_LSB];

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  logic [3:0] transmit_entry_count;
  logic       undervoltage_flag;
  logic       vco_calibration_error_flag;
  logic       pll_unlock_flag;
  logic [3:0] count_base;
  logic [3:0] next_transmit_entry_count;
  logic       next_undervoltage_flag;
  logic       next_vco_calibration_error_flag;
  logic       next_pll_unlock_flag;
  logic [7:0] status_view;

  // A read clears every sticky field, but an event in the same cycle as the
  // read survives it, so nothing is lost between the read and the clear.
  assign count_base = rd_stat ? 4'h0 : transmit_entry_count;
  // The four-bit sum drops its carry, so the count wraps from 15 to 0.
  assign next_transmit_entry_count = i_tx_active_entry ? 4'(count_base + 4'h1)
                                                       : count_base;
  assign next_undervoltage_flag          = (undervoltage_flag && !rd_stat)
                                           || i_undervoltage_detect;
  assign next_vco_calibration_error_flag = (vco_calibration_error_flag && !rd_stat)
                                           || i_vco_calibration_error;
  assign next_pll_unlock_flag            = (pll_unlock_flag && !rd_stat)
                                           || i_pll_unlock;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      transmit_entry_count       <= RST_ERROR_DETECTION_STATUS[TX_COUNT_MSB:TX_COUNT_LSB];
      undervoltage_flag          <= RST_ERROR_DETECTION_STATUS[UV_FLAG_BIT];
      vco_calibration_error_flag <= RST_ERROR_DETECTION_STATUS[VCO_ERR_BIT];
      pll_unlock_flag            <= RST_ERROR_DETECTION_STATUS[PLL_UNLK_BIT];
    end else begin
      transmit_entry_count       <= next_transmit_entry_count;
      undervoltage_flag          <= next_undervoltage_flag;
      vco_calibration_error_flag <= next_vco_calibration_error_flag;
      pll_unlock_flag            <= next_pll_unlock_flag;
    end
  end

  // The crystal check is a live level; it is not sticky and a read leaves it.
  assign status_view = {transmit_entry_count,
                        i_crystal_amplitude_ok,
                        undervoltage_flag,
                        vco_calibration_error_flag,
                        pll_unlock_flag};

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [7:0] next_reg_rdata;

  assign next_reg_rdata = sel_src  ? clock_output_source_divider :
                          sel_trim ? undervoltage_antenna_trim   :
                          sel_stat ? status_view                 :
                                     UNMAPPED_READ_VALUE;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_reg_rdata  <= UNMAPPED_READ_VALUE;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= next_reg_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  // Each stage passes enable pulses; the pin clocks toggle on them, so a
  // stage pulsing every N cycles yields a square wave of period 2N cycles.
  // That keeps every pin clock a clean flop output at the cost of a fixed
  // extra factor of two against the stage ratio.
  logic       ref16_tick;
  logic       presc_tick;
  logic       cmp_tick;
  logic       div_tick;
  logic [6:0] presc_limit;
  logic [2:0] post_limit;

  assign presc_limit = 7'((8'h01 << prescale_ratio_select) - 8'h01);
  assign post_limit  = 3'((4'h1 << post_divider_ratio_select) - 4'h1);

  rate_divider #(.W(3)) u_ref16 (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (1'b1),
    .i_limit   (REF16_HALF_LIMIT),
    .o_tick    (ref16_tick)
  );

  rate_divider #(.W(7)) u_prescale (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (1'b1),
    .i_limit   (presc_limit),
    .o_tick    (presc_tick)
  );

  rate_divider #(.W(8)) u_compare (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (presc_tick),
    .i_limit   (i_compare_divider_setting),
    .o_tick    (cmp_tick)
  );

  rate_divider #(.W(3)) u_postdiv (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_tick    (cmp_tick),
    .i_limit   (post_limit),
    .o_tick    (div_tick)
  );

  logic ref16_clk;
  logic presc_clk;
  logic div_clk;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ref16_clk <= 1'b0;
      presc_clk <= 1'b0;
      div_clk   <= 1'b0;
    end else begin
      ref16_clk <= ref16_clk ^ ref16_tick;
      presc_clk <= presc_clk ^ presc_tick;
      div_clk   <= div_clk ^ div_tick;
    end
  end

  // ----------------------------------------------------------------------
  // Output source select
  // ----------------------------------------------------------------------
  logic next_pin;
  logic next_pin_oe_n;

  always_comb begin
    next_pin      = 1'b0;
    next_pin_oe_n = 1'b0;
    unique case (clock_output_source_select)
      SRC_REF16: begin
        next_pin = ref16_clk;
      end
      SRC_PRESCALED: begin
        next_pin = presc_clk;
      end
      SRC_DIV_LOW: begin
        next_pin = i_power_amp_enabled ? div_clk : 1'b0;
      end
      SRC_DIVN_HIGH: begin
        next_pin = i_power_amp_enabled ? ~div_clk : 1'b1;
      end
      SRC_PA_REF16: begin
        next_pin      = ref16_clk;
        next_pin_oe_n = !i_power_amp_enabled;
      end
      SRC_PA_PRESC: begin
        next_pin      = presc_clk;
        next_pin_oe_n = !i_power_amp_enabled;
      end
      SRC_PA_DIV: begin
        next_pin      = div_clk;
        next_pin_oe_n = !i_power_amp_enabled;
      end
      SRC_PA_DIVN: begin
        next_pin      = ~div_clk;
        next_pin_oe_n = !i_power_amp_enabled;
      end
    endcase
  end

  // A last flop on the pin keeps the select mux from glitching onto it.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_clock_output_pin      <= 1'b0;
      o_clock_output_pin_oe_n <= 1'b0;
    end else begin
      o_clock_output_pin      <= next_pin;
      o_clock_output_pin_oe_n <= next_pin_oe_n;
    end
  end

endmodule
`default_nettype wire

// ===== clkout_divider_status_checker.sv
// Concurrent checks on the ports of the clock-output divider and status block.
`timescale 1ns/1ps
`default_nettype none
module clkout_divider_status_checker (
  input wire logic       i_clk_sys,                       // Clock.
  input wire logic       i_srst,                          // Reset.
  input wire logic [7:0] i_reg_addr,                      // Offset.
  input wire logic       i_reg_wr,                        // Write.
  input wire logic [7:0] i_reg_wdata,                     // Write data.
  input wire logic       i_reg_rd,                        // Read.
  input wire logic [7:0] o_reg_rdata,                     // Read data.
  input wire logic       o_reg_rvalid,                    // Read valid.
  input wire logic       i_power_amp_enabled,             // Amplifier on.
  input wire logic       i_tx_active_entry,               // Entry pulse.
  input wire logic       i_crystal_amplitude_ok,          // Crystal level.
  input wire logic       i_undervoltage_detect,           // Event.
  input wire logic       i_vco_calibration_error,         // Event.
  input wire logic       i_pll_unlock,                    // Event.
  input wire logic [1:0] o_undervoltage_threshold_select, // Threshold.
  input wire logic [4:0] o_antenna_cap_trim,              // Trim.
  input wire logic       o_clock_output_pin,              // Pin.
  input wire logic       o_clock_output_pin_oe_n          // Pin enable.
);
  import clkout_pkg::*;
  // ----------------------------------------------------------------------
  // Shadow of the source code and pin timing helpers
  // ----------------------------------------------------------------------
  logic [2:0] src;
  logic [5:0] age;
  logic       pin_q;
  logic [3:0] hold;
  wire        st_rd = i_reg_rd && (i_reg_addr == OFS_ERROR_DETECTION_STATUS);
  wire        quiet = !i_undervoltage_detect && !i_vco_calibration_error && !i_pll_unlock
                      && !i_tx_active_entry;
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      src <= 3'h0;
      age <= 6'h00;
    end else if (i_reg_wr && (i_reg_addr == OFS_CLOCK_OUTPUT_SOURCE_DIVIDER)) begin
      src <= i_reg_wdata[7:5];
      age <= 6'h00;
    end else if (age != 6'h3f) begin
      age <= age + 6'h01;
    end
  end
  // The period count saturates so a stopped pin cannot wrap into a false match.
  always_ff @(posedge i_clk_sys) begin
    pin_q <= o_clock_output_pin;
    hold  <= (o_clock_output_pin != pin_q) ? 4'h0 : ((hold == 4'hf) ? hold : hold + 4'h1);
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_reset_all_zero: assert property (@(posedge i_clk_sys)
    i_srst |=> (o_reg_rdata == 8'h00) && !o_reg_rvalid && !o_clock_output_pin_oe_n
    && (o_antenna_cap_trim == 5'h00))
    else $error("reset state");
  a_read_clears_status: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (st_rd && quiet) ##1 quiet ##1 (st_rd && quiet) |=> (o_reg_rdata & 8'hf7) == 8'h00)
    else $error("read clear");
  a_pll_flag_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_pll_unlock ##1 !st_rd ##1 st_rd |=> o_reg_rdata[PLL_UNLK_BIT])
    else $error("unlock flag");
  a_vco_flag_set: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_vco_calibration_error ##1 !st_rd ##1 st_rd |=> o_reg_rdata[VCO_ERR_BIT])
    else $error("vco flag");
  a_crystal_bit_live: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    st_rd |=> o_reg_rdata[XTAL_OK_BIT] == $past(i_crystal_amplitude_ok))
    else $error("crystal bit");
  a_code_low_held: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (src == SRC_DIV_LOW && !i_power_amp_enabled) [*2]
    |-> !o_clock_output_pin && !o_clock_output_pin_oe_n)
    else $error("code 2 level");
  a_code_high_held: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (src == SRC_DIVN_HIGH && !i_power_amp_enabled) [*2]
    |-> o_clock_output_pin && !o_clock_output_pin_oe_n)
    else $error("code 3 level");
  a_pin_released: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (src[2] && !i_power_amp_enabled) [*2] |-> o_clock_output_pin_oe_n)
    else $error("pin not released");
  a_pin_driven: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!src[2] || i_power_amp_enabled) [*2] |-> !o_clock_output_pin_oe_n)
    else $error("pin not driven");
  a_ref16_half_period: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (src == SRC_REF16 && age > 6'h28 && o_clock_output_pin != pin_q) |-> hold == 4'h7)
    else $error("ref16 period");
endmodule
bind clkout_divider_status clkout_divider_status_checker i_clkout_divider_status_checker (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid), .i_power_amp_enabled(i_power_amp_enabled),
  .i_tx_active_entry(i_tx_active_entry), .i_crystal_amplitude_ok(i_crystal_amplitude_ok),
  .i_undervoltage_detect(i_undervoltage_detect), .i_vco_calibration_error(i_vco_calibration_error),
  .i_pll_unlock(i_pll_unlock), .o_undervoltage_threshold_select(o_undervoltage_threshold_select),
  .o_antenna_cap_trim(o_antenna_cap_trim), .o_clock_output_pin(o_clock_output_pin),
  .o_clock_output_pin_oe_n(o_clock_output_pin_oe_n));
`default_nettype wire

// ===== clkout_divider_status_test.sv
// Self-checking testbench for the clock-output divider and status block.
`timescale 1ns/1ps
`default_nettype none
module clkout_divider_status_test;
  import clkout_pkg::*;
  logic       i_clk_sys, i_srst, i_reg_wr, i_reg_rd, o_reg_rvalid, pa, entry, xtal, uv, vco, pll;
  logic       pin, oe_n;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, ncmp;
  logic [1:0] thr;
  logic [4:0] trim;
  int         errors = 0;
  int         checked = 0;
  int         cycles = 0;
  clkout_divider_status i_clkout_divider_status (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid), .i_compare_divider_setting(ncmp), .i_power_amp_enabled(pa),
    .i_tx_active_entry(entry), .i_crystal_amplitude_ok(xtal), .i_undervoltage_detect(uv),
    .i_vco_calibration_error(vco), .i_pll_unlock(pll), .o_undervoltage_threshold_select(thr),
    .o_antenna_cap_trim(trim), .o_clock_output_pin(pin), .o_clock_output_pin_oe_n(oe_n));
  host_port_model i_host_port_model (
    .i_clk_sys(i_clk_sys), .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd), .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    i_host_port_model.read(a, d, ok);
    check({7'h00, ok, d}, {8'h01, exp});
  endtask
  // Event mask order is entry, under-voltage, calibration error, unlock.
  task automatic pulse(input logic [3:0] m);
    @(negedge i_clk_sys);
    {entry, uv, vco, pll} = m;
    @(negedge i_clk_sys);
    {entry, uv, vco, pll} = 4'h0;
  endtask
  task automatic wait_rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = pin;
      @(negedge i_clk_sys);
      n++;
    end while (!(pin && !prev) && n < 600);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_values();
    rd(OFS_CLOCK_OUTPUT_SOURCE_DIVIDER, 8'h00);
    rd(OFS_UNDERVOLTAGE_ANTENNA_TRIM, 8'h00);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h00);
    rd(8'h20, UNMAPPED_READ_VALUE);
    $display("test reset_values done");
  endtask
  task automatic t_register_access();
    i_host_port_model.write(OFS_UNDERVOLTAGE_ANTENNA_TRIM, 8'hff);
    rd(OFS_UNDERVOLTAGE_ANTENNA_TRIM, 8'h7f);
    check({9'h000, thr, trim}, 16'h007f);
    i_host_port_model.write(OFS_UNDERVOLTAGE_ANTENNA_TRIM, 8'hb5);
    rd(OFS_UNDERVOLTAGE_ANTENNA_TRIM, 8'h35);
    check({9'h000, thr, trim}, 16'h0035);
    i_host_port_model.write(OFS_ERROR_DETECTION_STATUS, 8'hff);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h00);
    i_host_port_model.write(OFS_CLOCK_OUTPUT_SOURCE_DIVIDER, 8'ha5);
    rd(OFS_CLOCK_OUTPUT_SOURCE_DIVIDER, 8'ha5);
    $display("test register_access done");
  endtask
  task automatic t_status();
    xtal = 1'b1;
    repeat (17) pulse(4'h8);
    pulse(4'h1);
    pulse(4'h2);
    pulse(4'h4);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h1f);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h08);
    xtal = 1'b0;
    rd(OFS_ERROR_DETECTION_STATUS, 8'h00);
    pulse(4'h1);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h01);
    pulse(4'h2);
    rd(OFS_ERROR_DETECTION_STATUS, 8'h02);
    $display("test status done");
  endtask
  task automatic t_static_codes();
    logic [2:0] c;
    pa = 1'b0;
    for (int k = 2; k < 8; k++) begin
      c = 3'(k);
      i_host_port_model.write(OFS_CLOCK_OUTPUT_SOURCE_DIVIDER, {c, 5'h00});
      repeat (3) @(negedge i_clk_sys);
      check({15'h0000, oe_n}, {15'h0000, c[2]});
      if (!c[2]) check({15'h0000, pin}, {15'h0000, c[0]});
    end
    $display("test static_codes done");
  endtask
  // A period is measured on the third rise so the divider has settled after the write.
  task automatic t_rates();
    logic [7:0] cfg [9] = '{8'h00, 8'h20, 8'h28, 8'h9c, 8'hbc, 8'hc6, 8'h43, 8'he1, 8'h61};
    logic [7:0] cmp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h04, 8'h01};
    logic       amp [9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    int         per [9] = '{16, 2, 8, 16, 256, 48, 16, 20, 8};
    int         n;
    for (int k = 0; k < 9; k++) begin
      pa = amp[k];
      ncmp = cmp[k];
      i_host_port_model.write(OFS_CLOCK_OUTPUT_SOURCE_DIVIDER, cfg[k]);
      wait_rise(n);
      wait_rise(n);
      wait_rise(n);
      check(16'(n), 16'(per[k]));
      check({15'h0000, oe_n}, 16'h0000);
    end
    $display("test rates done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {i_srst, pa, entry, xtal, uv, vco, pll} = 7'h40;
    ncmp = 8'h00;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_srst = 1'b0;
    t_reset_values();
    t_register_access();
    t_status();
    t_static_codes();
    t_rates();
    conclude();
  end
endmodule
`default_nettype wire

// ===== clkout_pkg.sv
// Constants shared by the clock-output divider and status register block.
package clkout_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_OUTPUT_SOURCE_DIVIDER = 8'h12;
  localparam logic [7:0] OFS_UNDERVOLTAGE_ANTENNA_TRIM   = 8'h13;
  localparam logic [7:0] OFS_ERROR_DETECTION_STATUS      = 8'h14;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CLOCK_OUTPUT_SOURCE_DIVIDER = 8'h00;
  localparam logic [7:0] RST_UNDERVOLTAGE_ANTENNA_TRIM   = 8'h00;
  localparam logic [7:0] RST_ERROR_DETECTION_STATUS      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE             = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SRC_SEL_MSB   = 7;
  localparam int SRC_SEL_LSB   = 5;
  localparam int PRESCALE_MSB  = 4;
  localparam int PRESCALE_LSB  = 2;
  localparam int POSTDIV_MSB   = 1;
  localparam int POSTDIV_LSB   = 0;
  localparam int UV_THRESH_MSB = 6;
  localparam int UV_THRESH_LSB = 5;
  localparam int ANT_TRIM_MSB  = 4;
  localparam int ANT_TRIM_LSB  = 0;
  localparam int TX_COUNT_MSB  = 7;
  localparam int TX_COUNT_LSB  = 4;
  localparam int XTAL_OK_BIT   = 3;
  localparam int UV_FLAG_BIT   = 2;
  localparam int VCO_ERR_BIT   = 1;
  localparam int PLL_UNLK_BIT  = 0;

  // ----------------------------------------------------------------------
  // Clock source codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_REF16      = 3'h0;
  localparam logic [2:0] SRC_PRESCALED  = 3'h1;
  localparam logic [2:0] SRC_DIV_LOW    = 3'h2;
  localparam logic [2:0] SRC_DIVN_HIGH  = 3'h3;
  localparam logic [2:0] SRC_PA_REF16   = 3'h4;
  localparam logic [2:0] SRC_PA_PRESC   = 3'h5;
  localparam logic [2:0] SRC_PA_DIV     = 3'h6;
  localparam logic [2:0] SRC_PA_DIVN    = 3'h7;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  // The reference/16 output toggles every half period of 16 reference cycles.
  localparam int         REF16_RATIO      = 16;
  localparam logic [2:0] REF16_HALF_LIMIT = 3'((REF16_RATIO / 2) - 1);

endpackage

// ===== host_port_model.sv
// Host controller model driving the register strobe port.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input  wire logic       i_clk_sys,    // Clock.
  output logic      [7:0] o_reg_addr,   // Offset.
  output logic            o_reg_wr,     // Write strobe.
  output logic      [7:0] o_reg_wdata,  // Write data.
  output logic            o_reg_rd,     // Read strobe.
  input  wire logic [7:0] i_reg_rdata,  // Read data.
  input  wire logic       i_reg_rvalid  // Read valid.
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end
  // Released lines show the inverse so a stale value is never mistaken for a hold.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_clk_sys);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge i_clk_sys);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_clk_sys);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    n = 0;
    while (!i_reg_rvalid && n < 4) begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = i_reg_rvalid;
    d = i_reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== rate_divider.sv
// Enable-pulse divider: passes one input tick out of every limit+1.
`timescale 1ns/1ps
`default_nettype none
module rate_divider #(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,  // Reference clock.
  input  wire logic         i_srst,     // Synchronous reset, active high.
  input  wire logic         i_tick,     // Input enable pulse.
  input  wire logic [W-1:0] i_limit,    // Terminal count, ratio is limit+1.
  output logic              o_tick      // Output enable pulse.
);

  logic [W-1:0] count;
  logic         at_limit;
  logic [W-1:0] next_count;

  // Greater-or-equal lets a smaller limit written mid-count take effect
  // at once instead of waiting for the counter to wrap.
  assign at_limit   = (count >= i_limit);
  assign o_tick     = i_tick && at_limit;
  assign next_count = at_limit ? '0 : W'(count + 1'b1);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      count <= '0;
    end else if (i_tick) begin
      count <= next_count;
    end
  end

endmodule
`default_nettype wire
